// >>> logic/auth_chip_wake_sleep_sequencer.sv
// wake, sleep and busy sequencing of the single-wire authentication device
// Functional notes
// - asleep, low pulses shorter than the deglitch window never wake the device
// - device starts asleep and stays there until a wake break arrives
// - valid break powers regulator; digital reset released about 20 us after the break falls
// - default configuration loaded from memory before any transaction
// - after loading, a ready break is sent back to the host
// - ready break falls 35 to 100 us after host break falls
// - after sleep opcode, wait at least 4 us before sleeping
// - with auto-sleep on, sleep after about one idle second
// - memory write keeps the device busy up to 1.9 ms
// - authentication result readable one bit time after the challenge
// - hashing starts once all 32 challenge bits are in
// - soft reset reloads and returns ready break within 30 us
// - all bit timing comes from the internal oscillator
// - memory is 16 bytes: config, trim, two lockable groups, general
// - device address and bus speed come from the configuration byte
// - pin only pulls low or releases, never drives high
// - device break lasts 1.391 bit times
// - awake, a short low pulse is a data bit, not a break
// - clearing auto-sleep enable disables it; reloaded at power-up and soft reset
// - entering sleep does not depend on the line level
`timescale 1ns/1ps
`default_nettype none
module auth_chip_wake_sleep_sequencer
  import seq_pkg::*;
#(
  parameter int AUTO_SLEEP_CYCLES = AUTO_CYC,
  parameter int WRITE_BUSY_CYCLES = WRITE_CYC
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       nrst,
  // single-wire pin
  input  wire logic       single_wire_bus_in,
  output var  logic       single_wire_bus_out,
  output var  logic       single_wire_bus_oe,
  // decoded frames
  input  wire command_t   command,
  input  wire mem_write_t mem_write,
  input  wire logic [3:0] mem_rd_addr,
  output var  logic [7:0] mem_rd_data,
  // status
  output var  logic       regulator_on,
  output var  logic       logic_run,
  output var  logic       accept,
  output var  logic       busy,
  output var  logic       hash_start,
  output var  logic       auth_ready,
  output var  logic       auto_sleep_enable,
  output var  logic       bit_tick,
  output var  config_t    cfg
);
  if (AUTO_SLEEP_CYCLES < 2 || WRITE_BUSY_CYCLES < 2) begin : g_bad
    $error("long counts must be at least 2");
  end

  localparam int AW = $clog2(AUTO_SLEEP_CYCLES + 1);
  localparam int BW = $clog2(WRITE_BUSY_CYCLES + 1);

  state_t     state;
  state_t     next_state;
  logic       line_q;
  logic       fall;
  logic       line_edge;
  logic [12:0] wake_count;
  logic [7:0]  sleep_count;
  logic [7:0]  break_ticks;
  logic [7:0]  hash_ticks;
  logic        hash_pending;
  logic        srst_flag;
  logic        osc_tick;
  logic        idle_done;
  logic        mem_wr_en;
  logic        locked;
  logic [AW-1:0] idle_count;
  logic [BW-1:0] busy_count;
  logic [3:0]    rd_addr;

  assign fall      = line_q && !single_wire_bus_in;
  assign line_edge = line_q ^ single_wire_bus_in;
  assign idle_done = (idle_count >= AW'(AUTO_SLEEP_CYCLES - 1));

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      line_q <= 1'b1;
    end else begin
      line_q <= single_wire_bus_in;
    end
  end

  assign single_wire_bus_out = 1'b0;
  assign single_wire_bus_oe  = (state == st_break);

  assign regulator_on = (state != st_sleep);
  assign logic_run    = (state != st_sleep) && (state != st_wake);
  assign accept       = (state == st_ready) && !busy;
  // hash starts on last challenge bit
  assign hash_start   = accept && command.challenge_done;
  assign busy         = (busy_count != '0);

  // deglitch counter armed by a fall
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wake_count <= '0;
    end else if (state == st_sleep) begin
      wake_count <= (!single_wire_bus_in && (fall || wake_count != '0)) ? wake_count + 1'b1 : '0;
    end else if (state != st_ready && state != st_sleep_wait) begin
      wake_count <= (wake_count == '1) ? wake_count : wake_count + 1'b1;
    end else begin
      wake_count <= '0;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      // stay asleep until a wake break
      st_sleep: begin
        if (!single_wire_bus_in && wake_count >= 13'(DEGLITCH_CYC)) begin
          next_state = st_wake;
        end
      end
      // release digital reset after 20 us
      st_wake: begin
        if (wake_count >= 13'(POR_CYC)) begin
          next_state = st_load;
        end
      end
      st_load: next_state = st_latch;
      st_latch: next_state = srst_flag ? st_break : st_wait;
      st_wait: begin
        if (wake_count >= 13'(READY_CYC)) begin
          next_state = st_break;
        end
      end
      st_break: begin
        if (osc_tick && break_ticks == 8'((BREAK_OSC << cfg.bus_speed) - 1)) begin
          next_state = st_ready;
        end
      end
      // low pulses here are data bits
      st_ready: begin
        if (accept && command.sleep_op) begin
          next_state = st_sleep_wait;
        end else if (accept && command.soft_reset) begin
          next_state = st_load;
        end else if (auto_sleep_enable && idle_done && !busy) begin
          next_state = st_sleep;
        end
      end
      // hold regulator 4 us after opcode
      st_sleep_wait: begin
        if (sleep_count >= 8'(SLEEP_CYC - 1)) begin
          next_state = st_sleep;
        end
      end
      default: next_state = st_sleep;
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= st_sleep;
    end else begin
      state <= next_state;
    end
  end

  // soft reset skips the wake wait
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      srst_flag <= 1'b0;
    end else if (accept && command.soft_reset) begin
      srst_flag <= 1'b1;
    end else if (state == st_sleep || state == st_ready) begin
      srst_flag <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sleep_count <= '0;
    end else if (state == st_sleep_wait) begin
      sleep_count <= sleep_count + 1'b1;
    end else begin
      sleep_count <= '0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      break_ticks <= '0;
    end else if (state != st_break) begin
      break_ticks <= '0;
    end else if (osc_tick) begin
      break_ticks <= break_ticks + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cfg <= '0;
    end else if (state == st_latch) begin
      cfg.device_address <= mem_rd_data[CFG_ADDR_LSB +: 2];
      cfg.bus_speed      <= mem_rd_data[CFG_SPEED_LSB +: 2];
      cfg.int_enable     <= mem_rd_data[CFG_INT_EN];
      cfg.lockout        <= {mem_rd_data[CFG_LOCK_A], mem_rd_data[CFG_LOCK_B]};
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      auto_sleep_enable <= 1'b0;
    end else if (state == st_latch) begin
      auto_sleep_enable <= mem_rd_data[CFG_AUTO_SLEEP];
    end else if (accept && command.auto_sleep_write) begin
      auto_sleep_enable <= command.auto_sleep_value;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      idle_count <= '0;
    end else if (state != st_ready || line_edge) begin
      idle_count <= '0;
    end else if (!idle_done) begin
      idle_count <= idle_count + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      busy_count <= '0;
    end else if (accept && command.write_done) begin
      busy_count <= BW'(WRITE_BUSY_CYCLES);
    end else if (state == st_sleep) begin
      busy_count <= '0;
    end else if (busy) begin
      busy_count <= busy_count - 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      hash_pending <= 1'b0;
      hash_ticks   <= '0;
      auth_ready   <= 1'b0;
    end else if (hash_start) begin
      hash_pending <= 1'b1;
      hash_ticks   <= '0;
      auth_ready   <= 1'b0;
    end else if (state != st_ready) begin
      hash_pending <= 1'b0;
      auth_ready   <= 1'b0;
    end else if (hash_pending && osc_tick) begin
      hash_ticks <= hash_ticks + 1'b1;
      if (hash_ticks == 8'((BIT_TIME_OSC << cfg.bus_speed) - 1)) begin
        hash_pending <= 1'b0;
        auth_ready   <= 1'b1;
      end
    end
  end

  always_comb begin
    locked = 1'b0;
    if (mem_write.addr >= ADDR_GROUP_A && mem_write.addr <= ADDR_GROUP_A_E) begin
      locked = cfg.lockout[1];
    end else if (mem_write.addr >= ADDR_GROUP_B && mem_write.addr <= ADDR_GROUP_B_E) begin
      locked = cfg.lockout[0];
    end
  end

  assign mem_wr_en = accept && mem_write.valid && !locked && (mem_write.addr != ADDR_TRIM);
  assign rd_addr   = (state == st_load) ? ADDR_CONFIG : mem_rd_addr;

  otp_memory u_mem (
    .clock   (clock),
    .nrst    (nrst),
    .wr_en   (mem_wr_en),
    .wr_addr (mem_write.addr),
    .wr_data (mem_write.data),
    .rd_addr (rd_addr),
    .rd_data (mem_rd_data)
  );

  osc_timebase u_time (
    .clock    (clock),
    .nrst     (nrst),
    .align    (state != st_break && next_state == st_break),
    .speed    (cfg.bus_speed),
    .osc_tick (osc_tick),
    .bit_tick (bit_tick)
  );

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence s_short_pulse;
    state == st_sleep && !line_q && single_wire_bus_in;
  endsequence

  sequence s_sleep_cmd;
    accept && command.sleep_op;
  endsequence

  a_deglitch_short: assert property (s_short_pulse |=> state == st_sleep)
    else $error("short pulse woke the device");
  a_wake_on_low: assert property ($rose(regulator_on) |-> $past(!single_wire_bus_in))
    else $error("woke without a low line");
  a_por_release: assert property ($rose(logic_run) |-> wake_count >= 13'(POR_CYC))
    else $error("digital reset released early");
  a_config_loaded: assert property ($rose(single_wire_bus_oe) |-> $past(state, 2) == st_load || srst_flag == 1'b0)
    else $error("break without configuration load");
  a_ready_window: assert property ($rose(single_wire_bus_oe) && !srst_flag |->
    wake_count >= 13'(WAKE_MIN_CYC) && wake_count <= 13'(WAKE_MAX_CYC))
    else $error("ready break outside window");
  a_sleep_wait: assert property (s_sleep_cmd |=> regulator_on [*8])
    else $error("regulator dropped too soon after sleep opcode");
  a_sleep_count: assert property (state == st_sleep_wait && next_state == st_sleep |->
    sleep_count >= 8'(SLEEP_CYC - 1))
    else $error("sleep wait shorter than 4 us");
  a_auto_sleep: assert property (state == st_ready && auto_sleep_enable && idle_done && !busy
    && !command.sleep_op && !command.soft_reset |=> state == st_sleep)
    else $error("auto-sleep not taken");
  a_write_busy: assert property (accept && command.write_done |=> busy && !accept)
    else $error("write did not raise busy");
  a_hash_delay: assert property (hash_start |=> !auth_ready [*8])
    else $error("result ready too early");
  a_srst_break: assert property (accept && command.soft_reset |-> ##[1:4] single_wire_bus_oe)
    else $error("soft reset break late");
  a_pin_low_only: assert property (single_wire_bus_oe |-> single_wire_bus_out == 1'b0
    && state == st_break)
    else $error("pin driven outside break");
  a_break_length: assert property ($fell(single_wire_bus_oe) |->
    $past(break_ticks) == 8'((BREAK_OSC << cfg.bus_speed) - 1))
    else $error("break length wrong");
  a_awake_no_wake: assert property (state == st_ready |=> state != st_wake)
    else $error("awake pulse taken as break");
endmodule : auth_chip_wake_sleep_sequencer
`default_nettype wire

// >>> logic/osc_timebase.sv
// oscillator tick and bit-time tick generator
`timescale 1ns/1ps
`default_nettype none
module osc_timebase
  import seq_pkg::*;
#(
  parameter int DIV = OSC_DIV
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       nrst,
  // control
  input  wire logic       align,
  input  wire logic [1:0] speed,
  // ticks
  output var  logic       osc_tick,
  output var  logic       bit_tick
);
  if (DIV < 2) begin : g_bad
    $error("osc_timebase needs DIV of at least 2");
  end

  logic [$clog2(DIV)-1:0] div_count;
  logic [7:0]             bit_count;
  logic [7:0]             bit_last;

  assign bit_last = 8'((BIT_TIME_OSC << speed) - 1);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      div_count <= '0;
      osc_tick  <= 1'b0;
    end else if (align) begin
      div_count <= '0;
      osc_tick  <= 1'b0;
    end else begin
      osc_tick  <= (div_count == ($clog2(DIV))'(DIV - 1));
      div_count <= (div_count == ($clog2(DIV))'(DIV - 1)) ? '0 : div_count + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bit_count <= '0;
      bit_tick  <= 1'b0;
    end else begin
      bit_tick <= osc_tick && (bit_count == bit_last);
      if (align) begin
        bit_count <= '0;
      end else if (osc_tick) begin
        bit_count <= (bit_count == bit_last) ? '0 : bit_count + 1'b1;
      end
    end
  end
endmodule : osc_timebase
`default_nettype wire

// >>> logic/otp_memory.sv
// sixteen-byte programmable memory with registered read
`timescale 1ns/1ps
`default_nettype none
module otp_memory
  import seq_pkg::*;
#(
  parameter int         DEPTH = MEM_DEPTH,
  parameter int         WIDTH = MEM_WIDTH,
  parameter logic [7:0] INIT0 = DEFAULT_CONFIG
) (
  // clock and reset
  input  wire logic                     clock,
  input  wire logic                     nrst,
  // write port
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input  wire logic [WIDTH-1:0]         wr_data,
  // read port
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output var  logic [WIDTH-1:0]         rd_data
);
  if (DEPTH != 16 || WIDTH != 8) begin : g_bad
    $error("otp_memory supports 16 x 8 only");
  end

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= (i == 0) ? INIT0 : '0;
      end
    end else if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule : otp_memory
`default_nettype wire

// >>> logic/seq_pkg.sv
// constants, field layouts and carrier types for the wake/sleep sequencer
package seq_pkg;
  localparam int CLOCK_HZ      = 40_000_000;
  localparam int CLOCK_NS      = 25;
  localparam int OSC_HZ        = 532_000;
  localparam int OSC_DIV       = CLOCK_HZ / OSC_HZ;
  localparam int BIT_TIME_OSC  = 23;
  localparam int BREAK_OSC     = 32;
  localparam int DEGLITCH_NS   = 10_000;
  localparam int DEGLITCH_CYC  = (DEGLITCH_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int POR_NS        = 20_000;
  localparam int POR_CYC       = (POR_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int READY_NS      = 60_000;
  localparam int READY_CYC     = (READY_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int WAKE_MIN_NS   = 35_000;
  localparam int WAKE_MIN_CYC  = (WAKE_MIN_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int WAKE_MAX_NS   = 100_000;
  localparam int WAKE_MAX_CYC  = WAKE_MAX_NS / CLOCK_NS;
  localparam int SLEEP_WAIT_NS = 4_000;
  localparam int SLEEP_CYC     = (SLEEP_WAIT_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int AUTO_SLEEP_MS = 1_000;
  localparam int AUTO_CYC      = (CLOCK_HZ / 1_000) * AUTO_SLEEP_MS;
  localparam int WRITE_BUSY_US = 1_900;
  localparam int WRITE_CYC     = (CLOCK_HZ / 1_000_000) * WRITE_BUSY_US;

  localparam int         MEM_DEPTH      = 16;
  localparam int         MEM_WIDTH      = 8;
  localparam logic [3:0] ADDR_CONFIG    = 4'h0;
  localparam logic [3:0] ADDR_TRIM      = 4'h1;
  localparam logic [3:0] ADDR_GROUP_A   = 4'h2;
  localparam logic [3:0] ADDR_GROUP_A_E = 4'h9;
  localparam logic [3:0] ADDR_GROUP_B   = 4'hA;
  localparam logic [3:0] ADDR_GROUP_B_E = 4'hD;
  localparam logic [3:0] ADDR_GENERAL   = 4'hE;

  localparam int         CFG_LOCK_B     = 0;
  localparam int         CFG_LOCK_A     = 1;
  localparam int         CFG_AUTO_SLEEP = 2;
  localparam int         CFG_INT_EN     = 3;
  localparam int         CFG_SPEED_LSB  = 4;
  localparam int         CFG_ADDR_LSB   = 6;
  localparam logic [7:0] DEFAULT_CONFIG = 8'h04;

  typedef enum logic [2:0] {
    st_sleep, st_wake, st_load, st_latch, st_wait, st_break, st_ready, st_sleep_wait
  } state_t;

  typedef struct packed {
    logic sleep_op;
    logic soft_reset;
    logic write_done;
    logic challenge_done;
    logic auto_sleep_write;
    logic auto_sleep_value;
  } command_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] addr;
    logic [7:0] data;
  } mem_write_t;

  typedef struct packed {
    logic [1:0] device_address;
    logic [1:0] bus_speed;
    logic       int_enable;
    logic [1:0] lockout;
  } config_t;
endpackage : seq_pkg

// >>> sim/auth_chip_wake_sleep_sequencer_tb_top.sv
// self-checking bench for the wake/sleep sequencer
`timescale 1ns/1ps
`default_nettype none
module auth_chip_wake_sleep_sequencer_tb_top
  import seq_pkg::*;
;
  localparam int SPD     = DEFAULT_CONFIG[5:4];
  localparam int AUTO    = 3000;
  localparam int WBUSY   = 50;
  localparam int BIT_CYC = (BIT_TIME_OSC << SPD) * OSC_DIV;
  localparam int BRK_CYC = (BREAK_OSC << SPD) * OSC_DIV;
  localparam int SRST    = 30_000 / CLOCK_NS;
  localparam int SHORT   = DEGLITCH_CYC * 6 / 10;
  localparam logic [7:0] LOCK_CFG = 8'h06;
  localparam command_t C_WRITE = '{write_done: 1'b1, default: 1'b0};
  localparam command_t C_CHAL  = '{challenge_done: 1'b1, default: 1'b0};
  localparam command_t C_SOFT  = '{soft_reset: 1'b1, default: 1'b0};
  localparam command_t C_SLEEP = '{sleep_op: 1'b1, default: 1'b0};
  localparam command_t C_AOFF  = '{auto_sleep_write: 1'b1, default: 1'b0};
  localparam command_t C_NONE  = '0;

  logic       clock = 1'b0;
  logic       nrst  = 1'b0;
  logic       line, sw_out, sw_oe, regulator_on, logic_run, accept, busy;
  logic       hash_start, auth_ready, auto_sleep_on, bit_tick;
  command_t   command     = '0;
  mem_write_t mem_write   = '0;
  logic [3:0] mem_rd_addr = 4'h0;
  logic [7:0] mem_rd_data;
  config_t    cfg;
  int         err_count   = 0;
  int         checks_done = 0;
  int         n;

  always #(CLOCK_NS / 2.0) clock = ~clock;

  auth_chip_wake_sleep_sequencer #(.AUTO_SLEEP_CYCLES(AUTO), .WRITE_BUSY_CYCLES(WBUSY)) u_dut (
    .clock(clock), .nrst(nrst), .single_wire_bus_in(line), .single_wire_bus_out(sw_out),
    .single_wire_bus_oe(sw_oe), .command(command), .mem_write(mem_write),
    .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data), .regulator_on(regulator_on),
    .logic_run(logic_run), .accept(accept), .busy(busy), .hash_start(hash_start),
    .auth_ready(auth_ready), .auto_sleep_enable(auto_sleep_on), .bit_tick(bit_tick), .cfg(cfg)
  );
  host_line_model u_host (.clock(clock), .dev_oe(sw_oe), .line(line));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s saw %0h want %0h", $time, msg, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude
  task automatic tick(input int k);
    repeat (k) begin
      @(posedge clock);
      #1;
    end
  endtask : tick
  function automatic logic pick(input int sel);
    case (sel)
      0: return regulator_on;
      1: return sw_oe;
      2: return busy;
      3: return auth_ready;
      default: return bit_tick;
    endcase
  endfunction : pick
  task automatic wait_for(input int sel, input logic v, input int lim, output int cnt);
    cnt = 0;
    while (pick(sel) !== v) begin
      tick(1);
      cnt++;
      if (cnt > lim) begin
        check(1'b0, 1'b1, "wait bound");
        conclude();
      end
    end
  endtask : wait_for
  task automatic cmd(input command_t c, input logic wv, input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    command <= c;
    mem_write <= '{valid: wv, addr: a, data: d};
    #1;
  endtask : cmd
  task automatic idle();
    cmd(C_NONE, 1'b0, 4'h0, 8'h00);
  endtask : idle
  task automatic mread(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock);
    mem_rd_addr <= a;
    tick(2);
    check(mem_rd_data, exp, "read");
  endtask : mread
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    cmd(C_WRITE, 1'b1, a, d);
    idle();
    wait_for(2, 1'b0, WBUSY + 10, n);
  endtask : wr

  task automatic t_glitch();
    check(regulator_on, 1'b0, "reset asleep");
    u_host.brk(SHORT);
    cmd(C_WRITE, 1'b0, 4'h0, 8'h00);
    idle();
    tick(600);
    check({regulator_on, busy, sw_oe}, 3'b000, "glitch");
    $display("glitch test done");
  endtask : t_glitch
  task automatic t_wake();
    fork
      u_host.brk(1000);
      wait_for(1, 1'b1, WAKE_MAX_CYC + 100, n);
    join
    check(n >= WAKE_MIN_CYC && n <= WAKE_MAX_CYC, 1'b1, "wake time");
    check({regulator_on, logic_run, accept}, 3'b110, "power up");
    check({line, sw_out}, 2'b00, "pull low");
    check(cfg, {DEFAULT_CONFIG[7:3], DEFAULT_CONFIG[1:0]}, "config");
    cmd(C_WRITE, 1'b0, 4'h0, 8'h00);
    idle();
    check(busy, 1'b0, "early command");
    wait_for(1, 1'b0, BRK_CYC + 100, n);
    check(n + 3 >= BRK_CYC && n + 2 <= BRK_CYC + 2, 1'b1, "break length");
    check({accept, auto_sleep_on}, {1'b1, DEFAULT_CONFIG[CFG_AUTO_SLEEP]}, "ready");
    $display("wake test done");
  endtask : t_wake
  task automatic t_write();
    cmd(C_WRITE, 1'b1, ADDR_GENERAL, 8'hA5);
    idle();
    check({busy, accept}, 2'b10, "busy");
    cmd(C_CHAL, 1'b0, 4'h0, 8'h00);
    check(hash_start, 1'b0, "busy refuse");
    idle();
    wait_for(2, 1'b0, WBUSY + 10, n);
    check(n + 2 >= WBUSY - 1 && n + 2 <= WBUSY + 1, 1'b1, "busy time");
    cmd(C_NONE, 1'b1, ADDR_TRIM, 8'hFF);
    idle();
    mread(ADDR_GENERAL, 8'hA5);
    mread(ADDR_TRIM, 8'h00);
    $display("write test done");
  endtask : t_write
  task automatic t_hash();
    cmd(C_CHAL, 1'b0, 4'h0, 8'h00);
    check({hash_start, auth_ready}, 2'b10, "hash start");
    idle();
    wait_for(3, 1'b1, BIT_CYC + 200, n);
    check(n + 1 >= BIT_CYC - OSC_DIV && n + 1 <= BIT_CYC + OSC_DIV, 1'b1, "auth time");
    $display("hash test done");
  endtask : t_hash
  task automatic t_soft();
    wr(ADDR_CONFIG, LOCK_CFG);
    cmd(C_AOFF, 1'b0, 4'h0, 8'h00);
    idle();
    check(auto_sleep_on, 1'b0, "auto sleep off");
    cmd(C_SOFT, 1'b0, 4'h0, 8'h00);
    idle();
    wait_for(1, 1'b1, SRST, n);
    check(auto_sleep_on, 1'b1, "auto sleep reload");
    check(cfg, {LOCK_CFG[7:3], LOCK_CFG[1:0]}, "config reload");
    wait_for(1, 1'b0, BRK_CYC + 100, n);
    check(accept, 1'b1, "ready again");
    wr(ADDR_GROUP_A, 8'h3C);
    wr(ADDR_GROUP_B, 8'hC3);
    mread(ADDR_GROUP_A, 8'h00);
    mread(ADDR_GROUP_B, 8'hC3);
    wr(ADDR_CONFIG, DEFAULT_CONFIG);
    $display("soft reset test done");
  endtask : t_soft
  task automatic t_sleep();
    u_host.hold(1'b1);
    cmd(C_SLEEP, 1'b0, 4'h0, 8'h00);
    idle();
    wait_for(0, 1'b0, SLEEP_CYC + 100, n);
    check(n + 1 >= SLEEP_CYC, 1'b1, "sleep wait");
    u_host.hold(1'b0);
    tick(DEGLITCH_CYC + 200);
    check(regulator_on, 1'b0, "stay asleep");
    $display("sleep test done");
  endtask : t_sleep
  task automatic t_auto();
    t_wake();
    wait_for(0, 1'b0, AUTO + 200, n);
    check(n >= AUTO - 10 && n <= AUTO + 10, 1'b1, "auto sleep");
    t_wake();
    cmd(C_AOFF, 1'b0, 4'h0, 8'h00);
    idle();
    u_host.brk(SHORT);
    tick(AUTO + 500);
    check({regulator_on, sw_oe}, 2'b10, "stay awake");
    wait_for(4, 1'b1, BIT_CYC + 10, n);
    tick(1);
    wait_for(4, 1'b1, BIT_CYC + 10, n);
    check(n + 1, BIT_CYC, "bit time");
    cmd(C_SLEEP, 1'b0, 4'h0, 8'h00);
    idle();
    wait_for(0, 1'b0, SLEEP_CYC + 100, n);
    $display("auto sleep test done");
  endtask : t_auto

  initial begin
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    tick(1);
    t_glitch();
    t_wake();
    t_write();
    t_hash();
    t_soft();
    t_sleep();
    t_auto();
    conclude();
  end
endmodule : auth_chip_wake_sleep_sequencer_tb_top
`default_nettype wire

// >>> sim/host_line_model.sv
// host end of the single-wire line: pull-up and break driver
`timescale 1ns/1ps
`default_nettype none
module host_line_model (
  // clock
  input  wire logic clock,
  // line
  input  wire logic dev_oe,
  output var  logic line
);
  logic host_low = 1'b0;
  assign line = ~(host_low | dev_oe);
  task automatic brk(input int n);
    @(posedge clock);
    host_low <= 1'b1;
    repeat (n) @(posedge clock);
    host_low <= 1'b0;
  endtask : brk
  task automatic hold(input logic v);
    @(posedge clock);
    host_low <= v;
  endtask : hold
endmodule : host_line_model
`default_nettype wire
